// ===== hw/stacked_flash_soft_reset.sv
// software reset interpreter for the two-die stacked flash
`timescale 1ns/10ps
module stacked_flash_soft_reset
    import soft_reset_pkg::*;
#(
    parameter int NAND_MAX_CYC = NAND_RST_MAX_CYC,
    parameter int NAND_MIN_CYC = NAND_RST_MIN_CYC
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    input  wire logic        i_clk_en,
    input  wire logic        i_spi_clk,
    input  wire logic        i_spi_cs_n,
    input  wire logic        i_serial_data_in,
    input  wire logic        i_nand_op_busy,
    output logic [1:0]       o_die_active_q,
    output logic             o_nor_armed_q,
    output logic             o_nor_in_reset_q,
    output logic             o_nand_in_reset_q,
    output logic             o_nor_abort_q,
    output logic             o_nand_abort_q,
    output logic             o_buf_sel_q,
    output logic             o_cmd_ignored_q
);

    link_frame_s  frame;
    logic [1:0]   cnt_s1_q;
    logic [1:0]   cnt_s2_q;
    logic [1:0]   cnt_prev_q;
    logic         cs_s1_q;
    logic         cs_s2_q;
    logic         cs_s3_q;
    logic         cs_s4_q;
    logic [7:0]   op_q;
    logic         op_vld_q;
    logic [7:0]   arg_q;
    logic         arg_vld_q;
    logic         frame_end;
    logic         busy;
    logic         cmd_take;
    rst_state_e   state_q;
    rst_state_e   state_d;
    logic [RST_CNT_W-1:0] cnt_q;
    logic [RST_CNT_W-1:0] cnt_d;
    logic         go_nor;
    logic         go_nand;
    logic [RST_CNT_W-1:0] nand_len;

    spi_opcode_shifter u_shifter (
        .i_spi_clk        (i_spi_clk),
        .i_spi_cs_n       (i_spi_cs_n),
        .i_serial_data_in (i_serial_data_in),
        .o_frame          (frame)
    );

    // two-flop crossings; the cs path runs one stage longer so the
    // last byte of a frame is latched before its end is seen
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            cnt_s1_q   <= BYTE_CNT_NONE;
            cnt_s2_q   <= BYTE_CNT_NONE;
            cnt_prev_q <= BYTE_CNT_NONE;
            cs_s1_q    <= 1'b1;
            cs_s2_q    <= 1'b1;
            cs_s3_q    <= 1'b1;
            cs_s4_q    <= 1'b1;
        end else if (i_clk_en) begin
            cnt_s1_q   <= frame.cnt_gray;
            cnt_s2_q   <= cnt_s1_q;
            cnt_prev_q <= cnt_s2_q;
            cs_s1_q    <= i_spi_cs_n;
            cs_s2_q    <= cs_s1_q;
            cs_s3_q    <= cs_s2_q;
            cs_s4_q    <= cs_s3_q;
        end
    end

    assign frame_end = cs_s3_q & ~cs_s4_q;
    assign busy      = (state_q != ST_READY);
    // a frame counts only if its opcode landed and it ended outside
    // recovery; short frames and frames cut by recovery fall out here
    assign cmd_take  = frame_end && op_vld_q && !busy;

    // opcode match, shared by the command decodes below except nor arming
    function automatic logic cmd_is(input logic       take,
                                    input logic [7:0] op,
                                    input logic [7:0] code);
        return take && (op == code);
    endfunction : cmd_is

    // byte capture from the link side
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            op_q      <= 8'h00;
            op_vld_q  <= 1'b0;
            arg_q     <= 8'h00;
            arg_vld_q <= 1'b0;
        end else if (i_clk_en) begin
            if (frame_end) begin
                op_vld_q  <= 1'b0;
                arg_vld_q <= 1'b0;
            end else if (cnt_s2_q == BYTE_CNT_ONE && cnt_prev_q == BYTE_CNT_NONE) begin
                op_q     <= frame.op;
                op_vld_q <= 1'b1;
            end else if (cnt_s2_q == BYTE_CNT_TWO && cnt_prev_q == BYTE_CNT_ONE) begin
                arg_q     <= frame.arg;
                arg_vld_q <= 1'b1;
            end
        end
    end

    // commands take effect at frame end; both dies see the reset
    // opcodes whichever one is active
    assign go_nor  = cmd_is(cmd_take, op_q, OP_RST_NOR)
                     && o_nor_armed_q;
    assign go_nand = cmd_is(cmd_take, op_q,
                            OP_RST_NAND);

    // recovery length depends on whether the nand die was working
    assign nand_len = i_nand_op_busy ? RST_CNT_W'(NAND_MAX_CYC)
                                     : RST_CNT_W'(NAND_MIN_CYC);

    // nor arming: set by 66h, dropped by any other command or by reset
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_nor_armed_q <= 1'b0;
        end else if (i_clk_en && cmd_take) begin
            o_nor_armed_q <= (op_q == OP_RST_ARM);
        end
    end

    // recovery sequencer
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            ST_READY: begin
                if (go_nor) begin
                    state_d = ST_NOR_RST;
                    cnt_d   = RST_CNT_W'(NOR_RST_CYC - 1);
                end else if (go_nand) begin
                    state_d = ST_NAND_RST;
                    cnt_d   = nand_len - RST_CNT_W'(1);
                end
            end
            ST_NOR_RST, ST_NAND_RST: begin
                if (cnt_q == '0) begin
                    state_d = ST_READY;
                end else begin
                    cnt_d = cnt_q - RST_CNT_W'(1);
                end
            end
            default: begin
                state_d = ST_READY;
                cnt_d   = '0;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            state_q <= ST_READY;
            cnt_q   <= '0;
        end else if (i_clk_en) begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_nor_in_reset_q  <= 1'b0;
            o_nand_in_reset_q <= 1'b0;
            o_nor_abort_q     <= 1'b0;
            o_nand_abort_q    <= 1'b0;
        end else if (i_clk_en) begin
            o_nor_in_reset_q  <= (state_d == ST_NOR_RST);
            o_nand_in_reset_q <= (state_d == ST_NAND_RST);
            o_nor_abort_q     <= go_nor;
            o_nand_abort_q    <= go_nand;
        end
    end

    // frames ending inside recovery are dropped whole
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_cmd_ignored_q <= 1'b0;
        end else if (i_clk_en) begin
            o_cmd_ignored_q <= frame_end && op_vld_q && busy;
        end
    end

    // die select; a bad id leaves both dies idle
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_die_active_q <= DIE_ACT_RST;
        end else if (i_clk_en && cmd_is(cmd_take, op_q, OP_DIE_SEL)
                     && arg_vld_q) begin
            if (arg_q == DIE_ID_NOR) begin
                o_die_active_q <= 2'h1;
            end else if (arg_q == DIE_ID_NAND) begin
                o_die_active_q <= 2'h2;
            end else begin
                o_die_active_q <= 2'h0;
            end
        end
    end

    // volatile nand setting: back to its default on every nand reset
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_buf_sel_q <= BUF_SEL_RST;
        end else if (i_clk_en) begin
            if (go_nand) begin
                o_buf_sel_q <= BUF_SEL_RST;
            end else if (cmd_is(cmd_take, op_q, OP_BUF_WR) && arg_vld_q
                         && o_die_active_q[1]) begin
                o_buf_sel_q <= arg_q[BUF_ARG_BIT];
            end
        end
    end

endmodule : stacked_flash_soft_reset

// ===== hw/soft_reset_pkg.sv
// constants and types for the stacked flash software reset block
// Function
// - nor die resets only after 66h then 99h
// - any other command drops nor reset arming
// - nor reset recovers 30us, commands ignored
// - nand die resets on FFh frame
// - nand recovery 5us to 500us, commands ignored
// - buffered-read select resets zero, writable one
// - one active die, die 0 first, C2h selects; a bad id here leaves neither die active
// - reset opcodes accepted by active or idle die
// - reset aborts die operation, clears volatile state
package soft_reset_pkg;

    localparam logic [7:0]  OP_RST_ARM     = 8'h66;
    localparam logic [7:0]  OP_RST_NOR     = 8'h99;
    localparam logic [7:0]  OP_RST_NAND    = 8'hFF;
    localparam logic [7:0]  OP_DIE_SEL     = 8'hC2;
    localparam logic [7:0]  OP_BUF_WR      = 8'h1F;
    localparam logic [7:0]  DIE_ID_NOR     = 8'h00;
    localparam logic [7:0]  DIE_ID_NAND    = 8'h01;
    localparam int          BUF_ARG_BIT    = 3;
    localparam logic [1:0]  DIE_ACT_RST    = 2'h1;
    localparam logic        BUF_SEL_RST    = 1'b0;

    localparam logic [1:0]  BYTE_CNT_NONE  = 2'h0;
    localparam logic [1:0]  BYTE_CNT_ONE   = 2'h1;
    localparam logic [1:0]  BYTE_CNT_TWO   = 2'h3;

    localparam int          SYS_CLK_NS     = 10;
    localparam int          NOR_RST_NS     = 30000;
    localparam int          NAND_RST_MIN_NS = 5000;
    localparam int          NAND_RST_MAX_NS = 500000;
    localparam int          NOR_RST_CYC    = NOR_RST_NS / SYS_CLK_NS;
    localparam int          NAND_RST_MIN_CYC = (NAND_RST_MIN_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int          NAND_RST_MAX_CYC = NAND_RST_MAX_NS / SYS_CLK_NS;
    localparam int          RST_CNT_W      = 20;

    typedef struct packed {
        logic [7:0] op;
        logic [7:0] arg;
        logic [1:0] cnt_gray;
    } link_frame_s;

    typedef enum logic [1:0] {
        ST_READY,
        ST_NOR_RST,
        ST_NAND_RST
    } rst_state_e;

endpackage : soft_reset_pkg

// ===== hw/spi_opcode_shifter.sv
// link-side shifter: captures first two bytes of each spi frame
`timescale 1ns/10ps
module spi_opcode_shifter
    import soft_reset_pkg::*;
(
    input  wire logic        i_spi_clk,
    input  wire logic        i_spi_cs_n,
    input  wire logic        i_serial_data_in,
    output link_frame_s      o_frame
);

    logic [2:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic [1:0] cnt_gray_q;
    logic [7:0] op_q;
    logic [7:0] arg_q;

    // cs high clears the counters: the spi clock stops between frames
    always_ff @(posedge i_spi_clk or posedge i_spi_cs_n) begin
        if (i_spi_cs_n) begin
            bit_cnt_q  <= 3'h0;
            shift_q    <= 7'h00;
            cnt_gray_q <= BYTE_CNT_NONE;
        end else begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            shift_q   <= {shift_q[5:0], i_serial_data_in};
            if (bit_cnt_q == 3'h7) begin
                if (cnt_gray_q == BYTE_CNT_NONE) begin
                    cnt_gray_q <= BYTE_CNT_ONE;
                end else begin
                    cnt_gray_q <= BYTE_CNT_TWO;
                end
            end
        end
    end

    // bytes hold steady long after the count moves, so the sys side
    // may read them once the gray count has crossed
    always_ff @(posedge i_spi_clk) begin
        if (!i_spi_cs_n && bit_cnt_q == 3'h7) begin
            if (cnt_gray_q == BYTE_CNT_NONE) begin
                op_q <= {shift_q, i_serial_data_in};
            end else if (cnt_gray_q == BYTE_CNT_ONE) begin
                arg_q <= {shift_q, i_serial_data_in};
            end
        end
    end

    assign o_frame = '{op: op_q, arg: arg_q, cnt_gray: cnt_gray_q};

endmodule : spi_opcode_shifter

// ===== bench/soft_reset_checker.sv
// assertions on the soft reset block ports
`timescale 1ns/10ps
module soft_reset_checker
    import soft_reset_pkg::*;
#(
    parameter int NAND_MAX_CYC = 200,
    parameter int NAND_MIN_CYC = 20
) (
    input wire logic       i_clk_sys,
    input wire logic       i_sys_rst,
    input wire logic [1:0] o_die_active_q,
    input wire logic       o_nor_armed_q,
    input wire logic       o_nor_in_reset_q,
    input wire logic       o_nand_in_reset_q,
    input wire logic       o_nor_abort_q,
    input wire logic       o_nand_abort_q,
    input wire logic       o_buf_sel_q,
    input wire logic       o_cmd_ignored_q
);
    logic [19:0] nor_cnt_q;
    logic [19:0] nand_cnt_q;
    // counts recovery length; read in the cycle after the fall
    always_ff @(posedge i_clk_sys) begin
        nor_cnt_q <= (i_sys_rst || !o_nor_in_reset_q) ? 20'h0 : nor_cnt_q + 20'h1;
    end
    always_ff @(posedge i_clk_sys) begin
        nand_cnt_q <= (i_sys_rst || !o_nand_in_reset_q) ? 20'h0 : nand_cnt_q + 20'h1;
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    property p_nor_start;
        $rose(o_nor_in_reset_q) |-> o_nor_abort_q && !o_nor_armed_q && $past(o_nor_armed_q);
    endproperty
    a_nor_start: assert property (p_nor_start) else $error("nor reset without arming");
    property p_nor_len;
        $fell(o_nor_in_reset_q) |-> nor_cnt_q == NOR_RST_CYC;
    endproperty
    a_nor_len: assert property (p_nor_len) else $error("nor recovery length wrong");
    property p_nand_len;
        $fell(o_nand_in_reset_q) |-> nand_cnt_q == NAND_MIN_CYC || nand_cnt_q == NAND_MAX_CYC;
    endproperty
    a_nand_len: assert property (p_nand_len) else $error("nand recovery length wrong");
    property p_nand_start;
        $rose(o_nand_in_reset_q) |-> o_nand_abort_q && !o_buf_sel_q;
    endproperty
    a_nand_start: assert property (p_nand_start) else $error("nand reset start wrong");
    property p_ignored;
        o_cmd_ignored_q |-> $past(o_nor_in_reset_q || o_nand_in_reset_q)
            || $past(o_nor_in_reset_q || o_nand_in_reset_q, 2);
    endproperty
    a_ignored: assert property (p_ignored) else $error("frame dropped outside recovery");
    property p_nor_quiet;
        $past(o_nor_in_reset_q) && o_nor_in_reset_q |->
            $stable(o_die_active_q) && $stable(o_nor_armed_q) && !o_nand_abort_q;
    endproperty
    a_nor_quiet: assert property (p_nor_quiet) else $error("command taken in nor recovery");
    property p_nand_quiet;
        $past(o_nand_in_reset_q) && o_nand_in_reset_q |->
            $stable(o_die_active_q) && $stable(o_buf_sel_q) && !o_nor_abort_q;
    endproperty
    a_nand_quiet: assert property (p_nand_quiet) else $error("command taken in nand recovery");
    property p_one_die;
        o_die_active_q != 2'h3;
    endproperty
    a_one_die: assert property (p_one_die) else $error("both dies active");
    property p_arm_idle;
        o_nor_armed_q |-> !o_nor_in_reset_q;
    endproperty
    a_arm_idle: assert property (p_arm_idle) else $error("arming kept through reset");
    c_nor: cover property ($fell(o_nor_in_reset_q));
    c_ign: cover property (o_cmd_ignored_q);
    c_nand_max: cover property ($fell(o_nand_in_reset_q) && nand_cnt_q == NAND_MAX_CYC);
endmodule : soft_reset_checker

// ===== bench/spi_host_model.sv
// spi host model sending opcode frames
`timescale 1ns/10ps
module spi_host_model (
    output logic o_spi_clk,
    output logic o_spi_cs_n,
    output logic o_sdo
);
    initial begin
        o_spi_clk = 1'b0;
        o_spi_cs_n = 1'b1;
        o_sdo = 1'b1;
    end
    // clock stands still between frames; data flips once released
    task automatic frame(input logic [15:0] bits, input int n);
        o_spi_cs_n = 1'b0;
        // 48 ns bit time: data set mid-low, 24 ns high
        for (int i = 0; i < n; i++) begin
            #12 o_sdo = bits[15-i];
            #12 o_spi_clk = 1'b1;
            #24 o_spi_clk = 1'b0;
        end
        #24 o_spi_cs_n = 1'b1;
        o_sdo = ~o_sdo;
        #80;
    endtask : frame
endmodule : spi_host_model

// ===== bench/tb.sv
// testbench for the stacked flash soft reset block
`timescale 1ns/10ps
module tb
    import soft_reset_pkg::*;
;
    logic        i_clk_sys = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        busy = 1'b0;
    wire logic   spi_clk, cs_n, sdi;
    logic [1:0]  die_act;
    logic        armed, nor_rst, nand_rst, nor_ab, nand_ab, buf_sel, ign;
    int          bad_count = 0;
    int          compares = 0;
    logic [31:0] lfsr_q = 32'hE2E3;
    logic [2:0]  exp_q[$];
    always #5 i_clk_sys = ~i_clk_sys;
    spi_host_model host (.o_spi_clk(spi_clk), .o_spi_cs_n(cs_n), .o_sdo(sdi));
    stacked_flash_soft_reset #(.NAND_MAX_CYC(200), .NAND_MIN_CYC(20)) dut (
        .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_clk_en(1'b1),
        .i_spi_clk(spi_clk), .i_spi_cs_n(cs_n), .i_serial_data_in(sdi),
        .i_nand_op_busy(busy), .o_die_active_q(die_act), .o_nor_armed_q(armed),
        .o_nor_in_reset_q(nor_rst), .o_nand_in_reset_q(nand_rst), .o_nor_abort_q(nor_ab),
        .o_nand_abort_q(nand_ab), .o_buf_sel_q(buf_sel), .o_cmd_ignored_q(ign));
    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task automatic print_verdict();
        if (bad_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    // ev: expected pulse code {nor abort, nand abort, dropped}
    task automatic cmd(input logic [7:0] op, input logic [7:0] arg, input int n,
                       input logic [2:0] ev);
        if (ev != 3'h0) exp_q.push_back(ev);
        host.frame({op, arg}, n);
        @(negedge i_clk_sys);
    endtask : cmd
    task automatic wait_idle();
        int k;
        for (k = 0; k < 5000 && (nor_rst | nand_rst) !== 1'b0; k++) @(negedge i_clk_sys);
        if (k == 5000) begin
            bad_count++;
            $display("mismatch %0t recovery never ended", $time);
            print_verdict();
        end
    endtask : wait_idle
    // pulses are matched to the oldest note; a stray pulse compares to zero
    always @(negedge i_clk_sys) begin
        if ({nor_ab, nand_ab, ign} !== 3'h0 && !i_sys_rst) begin
            if (exp_q.size() == 0) chk({nor_ab, nand_ab, ign}, 3'h0);
            else chk({nor_ab, nand_ab, ign}, exp_q.pop_front());
        end
    end
    initial begin
        repeat (6) @(negedge i_clk_sys);
        i_sys_rst = 1'b0;
        repeat (5) @(negedge i_clk_sys);
        chk({buf_sel, die_act}, {BUF_SEL_RST, DIE_ACT_RST});
        chk({armed, nor_rst, nand_rst}, 3'h0);
        cmd(OP_DIE_SEL, DIE_ID_NAND, 16, 3'h0);
        chk(die_act, 2'h2);
        cmd(OP_BUF_WR, 8'h08, 16, 3'h0);
        chk(buf_sel, 1'b1);
        cmd(OP_RST_ARM, 8'h00, 8, 3'h0);
        chk(armed, 1'b1);
        do lfsr_q = lfsr_next(lfsr_q);
        while (lfsr_q[7:0] inside {OP_RST_NOR, OP_RST_ARM, OP_RST_NAND, OP_DIE_SEL, OP_BUF_WR});
        cmd(lfsr_q[7:0], 8'h00, 8, 3'h0);
        chk(armed, 1'b0);
        cmd(OP_RST_NOR, 8'h00, 8, 3'h0);
        chk(nor_rst, 1'b0);
        cmd(OP_RST_ARM, 8'h00, 8, 3'h0);
        cmd(OP_RST_NOR, 8'h00, 8, 3'h4);
        chk({nor_rst, armed, buf_sel}, 3'h5);
        // die select stays out of recovery; a dropped 66h must not arm
        cmd(OP_RST_ARM, 8'h00, 8, 3'h1);
        chk({armed, die_act}, 3'h2);
        wait_idle();
        cmd(OP_RST_NOR, 8'h00, 8, 3'h0);
        chk(nor_rst, 1'b0);
        cmd(OP_DIE_SEL, DIE_ID_NOR, 16, 3'h0);
        chk(die_act, 2'h1);
        // short recovery ends before a second frame can land, so drop only on busy
        for (int b = 0; b < 2; b++) begin
            busy = b[0];
            cmd(OP_RST_NAND, 8'h00, 8, 3'h2);
            chk({nand_rst, buf_sel}, 2'h2);
            if (b == 1) cmd(OP_RST_NAND, 8'h00, 8, 3'h1);
            wait_idle();
            cmd(OP_DIE_SEL, DIE_ID_NAND, 16, 3'h0);
            cmd(OP_BUF_WR, 8'h08, 16, 3'h0);
        end
        cmd(OP_DIE_SEL, 8'h07, 16, 3'h0);
        chk(die_act, 2'h0);
        cmd(OP_RST_NAND, 8'h00, 4, 3'h0);
        chk(nand_rst, 1'b0);
        repeat (10) @(negedge i_clk_sys);
        chk(3'(exp_q.size()), 3'h0);
        print_verdict();
    end
endmodule : tb
bind stacked_flash_soft_reset soft_reset_checker #(
    .NAND_MAX_CYC(NAND_MAX_CYC), .NAND_MIN_CYC(NAND_MIN_CYC)) chk_i (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .o_die_active_q(o_die_active_q),
    .o_nor_armed_q(o_nor_armed_q), .o_nor_in_reset_q(o_nor_in_reset_q),
    .o_nand_in_reset_q(o_nand_in_reset_q), .o_nor_abort_q(o_nor_abort_q),
    .o_nand_abort_q(o_nand_abort_q), .o_buf_sel_q(o_buf_sel_q),
    .o_cmd_ignored_q(o_cmd_ignored_q));
